/* File: hw/umc_pkg.sv */
// Functional notes
// - port disabled: pins revert to port latches
// - idle-stop bit halts port in idle
// - infrared codec only when high-speed select zero
// - rts mode: 1 simplex, 0 flow control
// - pin usage field selects driven pins
// - wake: falling rx edge interrupts, rising clears
// - loopback routes transmit back to receiver
// - bits 14, 10 read zero; reset zero
package umc_pkg;
    // register byte addresses
    localparam logic [3:0] ADDR_MODE   = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_MASK   = 4'h8;
    // mode register bit positions
    localparam int BIT_EN     = 15;
    localparam int BIT_SIDL   = 13;
    localparam int BIT_INFRARED_CODEC_ENABLE   = 12;
    localparam int BIT_RTS_PIN_MODE_BIT  = 11;
    localparam int BIT_UEN_LO = 8;
    localparam int BIT_WAKE   = 7;
    localparam int BIT_LOOPBACK_SELECT = 6;
    localparam int BIT_AUTO_BAUD_ENABLE  = 5;
    localparam int BIT_HIGH_SPEED_BAUD_SELECT   = 3;
    localparam logic [15:0] MODE_WMASK = 16'hbbff;
    localparam logic [15:0] MODE_RESET = 16'h0000;
    // status / mask bits
    localparam int EV_WAKE  = 0;
    localparam int EV_AUTO_BAUD_ENABLE = 1;
    localparam int EV_W     = 2;
    localparam logic [1:0] AXI_OKAY   = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;
    // pin usage encodings
    typedef enum logic [1:0] {
        UMC_PINS_TXRX, UMC_PINS_RTS, UMC_PINS_RTSCTS, UMC_PINS_BCLK
    } umc_pins_e;
    // pin driver controls
    typedef struct packed {
        logic tx_own;
        logic rts_own;
        logic cts_own;
        logic bclk_own;
    } umc_pinsel_s;
endpackage

/* File: hw/umc_top.sv */
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
module umc_top
    import umc_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // axi4-lite slave
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // device power state
    input  wire logic        dev_idle,
    input  wire logic        dev_sleep,
    // serial core side
    input  wire logic        core_tx,
    input  wire logic        core_rts,
    input  wire logic        core_bclk,
    input  wire logic        auto_baud_enable_done,
    output logic             core_rx,
    output logic             core_run,
    output logic             core_hold_idle,
    output logic             core_ir_en,
    output logic             core_rts_simplex,
    output logic             core_auto_baud_enable_go,
    // pins
    input  wire logic        receive_pin,
    input  wire logic        clear_to_send_pin,
    output logic             transmit_pin,
    output logic             transmit_pin_oe,
    output logic             request_to_send_pin,
    output logic             request_to_send_pin_oe,
    output logic             bclk_pin,
    output logic             bclk_pin_oe,
    output logic             core_cts,
    // interrupt
    output logic             irq
);
    // register state, bus holding registers and edge trackers
    logic [15:0]         serial_port_mode;
    logic [EV_W-1:0]     ev_status;
    logic [EV_W-1:0]     ev_mask;
    logic                aw_held;
    logic                w_held;
    logic [3:0]          aw_addr;
    logic [31:0]         w_data;
    logic [3:0]          w_strb;
    logic                rx_prev;
    logic                wake_armed;
    logic                auto_baud_enable_seen;
    umc_pinsel_s         next_pinsel;
    logic                wr_fire;
    logic                rd_fire;
    logic                en;
    logic [EV_W-1:0]     ev_set;
    logic [15:0]         mode_clr;

    // enable is the master switch for every pin and for the core, except the rts mode output and core_rx, which follow their own bits, core_tx and the rx pin alone
    assign en = serial_port_mode[BIT_EN];

    // byte lane merge for a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
        merge16 = old;
        if (s[0]) merge16[7:0] = d[7:0];
        if (s[1]) merge16[15:8] = d[15:8];
    endfunction

    // one decode for the three mapped words, shared by both channels
    function automatic logic reg_known(input logic [3:0] a);
        if (a == ADDR_MODE)
            reg_known = 1'b1;
        else if (a == ADDR_STATUS)
            reg_known = 1'b1;
        else if (a == ADDR_MASK)
            reg_known = 1'b1;
        else
            reg_known = 1'b0;
    endfunction

    // write address is caught and held until the data joins it; ready pulses
    // so a held address can never be overwritten by a second one
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            aw_held       <= 1'b0;
            aw_addr       <= 4'h0;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (wr_fire)
                aw_held <= 1'b0;
        end
    end

    // write data is caught on its own ready, in either order with the address
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            w_held       <= 1'b0;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !w_held && !s_axi_wready;
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire)
                w_held <= 1'b0;
        end
    end

    // write response
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= AXI_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            if (reg_known(aw_addr))
                s_axi_bresp <= AXI_OKAY;
            else
                s_axi_bresp <= AXI_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // hardware-cleared mode bits
    always_comb begin
        mode_clr = 16'h0000;
        mode_clr[BIT_WAKE]  = wake_armed && rx_prev == 1'b0 && receive_pin;
        mode_clr[BIT_AUTO_BAUD_ENABLE] = serial_port_mode[BIT_AUTO_BAUD_ENABLE] && auto_baud_enable_done;
    end

    // mode register: any software write to it wins over the hardware clear in every bit, strobed or not
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            serial_port_mode <= MODE_RESET;
        end else if (wr_fire && aw_addr == ADDR_MODE) begin
            serial_port_mode <= merge16(serial_port_mode, w_data, w_strb) & MODE_WMASK;
        end else begin
            serial_port_mode <= serial_port_mode & ~mode_clr;
        end
    end

    // mask register
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ev_mask <= '0;
        end else if (wr_fire && aw_addr == ADDR_MASK && w_strb[0]) begin
            ev_mask <= w_data[EV_W-1:0];
        end
    end

    // wake edge detection keeps sampling rx during sleep
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rx_prev    <= 1'b1;
            wake_armed <= 1'b0;
        end else begin
            rx_prev <= receive_pin;
            if (!serial_port_mode[BIT_WAKE])
                wake_armed <= 1'b0;
            else if (dev_sleep && rx_prev && !receive_pin)
                wake_armed <= 1'b1;
        end
    end

    // events
    always_comb begin
        ev_set = '0;
        ev_set[EV_WAKE]  = serial_port_mode[BIT_WAKE] && dev_sleep && rx_prev &&
                           !receive_pin;
        ev_set[EV_AUTO_BAUD_ENABLE] = mode_clr[BIT_AUTO_BAUD_ENABLE];
    end

    // sticky status, cleared by read; a new event wins over the clear
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ev_status <= '0;
        end else begin
            if (rd_fire && s_axi_araddr == ADDR_STATUS)
                ev_status <= ev_set;
            else
                ev_status <= ev_status | ev_set;
        end
    end

    // level interrupt, a cycle behind the status it reflects
    always_ff @(posedge sys_clk) begin
        if (sys_rst)
            irq <= 1'b0;
        else
            irq <= |(ev_status & ev_mask);
    end

    // read channel, one-cycle answer
    assign rd_fire = s_axi_arvalid && s_axi_arready;

    // address ready drops while an answer waits, so one read is in flight at most
    always_ff @(posedge sys_clk) begin
        if (sys_rst)
            s_axi_arready <= 1'b0;
        else
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && !rd_fire;
    end

    // read answer stands until rready is sampled high
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= AXI_OKAY;
        end else begin
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= reg_known(s_axi_araddr) ? AXI_OKAY : AXI_SLVERR;
                if (s_axi_araddr == ADDR_MODE)
                    s_axi_rdata <= {16'h0000, serial_port_mode};
                else if (s_axi_araddr == ADDR_STATUS)
                    s_axi_rdata <= {{(32-EV_W){1'b0}}, ev_status};
                else if (s_axi_araddr == ADDR_MASK)
                    s_axi_rdata <= {{(32-EV_W){1'b0}}, ev_mask};
                else begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= AXI_SLVERR;
                end
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // pin ownership from the usage field
    always_comb begin
        next_pinsel = '0;
        if (en) begin
            next_pinsel.tx_own = 1'b1;
            case (umc_pins_e'(serial_port_mode[BIT_UEN_LO+:2]))
                UMC_PINS_RTS:    next_pinsel.rts_own = 1'b1;
                UMC_PINS_RTSCTS: begin
                    next_pinsel.rts_own = 1'b1;
                    next_pinsel.cts_own = 1'b1;
                end
                UMC_PINS_BCLK:   next_pinsel.bclk_own = 1'b1;
                default:         next_pinsel.rts_own = 1'b0;
            endcase
        end
    end

    // a measurement begun stays flagged until done so the core is started once
    always_ff @(posedge sys_clk) begin
        if (sys_rst || !en)
            auto_baud_enable_seen <= 1'b0;
        else
            auto_baud_enable_seen <= serial_port_mode[BIT_AUTO_BAUD_ENABLE] && !auto_baud_enable_done;
    end

    // transmit pin; loopback keeps tx off the pin so the far side sees the latch level
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            transmit_pin    <= 1'b1;
            transmit_pin_oe <= 1'b0;
        end else begin
            transmit_pin    <= core_tx;
            transmit_pin_oe <= next_pinsel.tx_own && !serial_port_mode[BIT_LOOPBACK_SELECT];
        end
    end

    // request-to-send pin, driven only when the usage field hands it over
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            request_to_send_pin    <= 1'b1;
            request_to_send_pin_oe <= 1'b0;
        end else begin
            request_to_send_pin    <= core_rts;
            request_to_send_pin_oe <= next_pinsel.rts_own;
        end
    end

    // baud clock pin shares the usage field with the handshake pins
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            bclk_pin    <= 1'b0;
            bclk_pin_oe <= 1'b0;
        end else begin
            bclk_pin    <= core_bclk;
            bclk_pin_oe <= next_pinsel.bclk_own;
        end
    end

    // receive side of the core; an unowned clear-to-send pin is not passed on
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            core_rx  <= 1'b1;
            core_cts <= 1'b0;
        end else begin
            core_rx  <= serial_port_mode[BIT_LOOPBACK_SELECT] ? core_tx : receive_pin;
            core_cts <= next_pinsel.cts_own ? clear_to_send_pin : 1'b0;
        end
    end

    // run and hold; idle-stop only matters while the port is on
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            core_run       <= 1'b0;
            core_hold_idle <= 1'b1;
        end else begin
            core_run       <= en && !(serial_port_mode[BIT_SIDL] && dev_idle);
            core_hold_idle <= !en;
        end
    end

    // codec, rts mode and baud measurement controls
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            core_ir_en       <= 1'b0;
            core_rts_simplex <= 1'b0;
            core_auto_baud_enable_go    <= 1'b0;
        end else begin
            // the codec timing only fits the 16x clock, so a fast baud setting vetoes it
            core_ir_en       <= en && serial_port_mode[BIT_INFRARED_CODEC_ENABLE] &&
                                !serial_port_mode[BIT_HIGH_SPEED_BAUD_SELECT];
            core_rts_simplex <= serial_port_mode[BIT_RTS_PIN_MODE_BIT];
            core_auto_baud_enable_go    <= en && auto_baud_enable_seen;
        end
    end
endmodule

/* File: tb/umc_chk.sv */
`timescale 1ns/100ps
module umc_chk
    import umc_pkg::*;
(
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    // bus answers
    input wire logic [3:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    // port state
    input wire logic        core_hold_idle,
    input wire logic        core_run,
    input wire logic        core_rx,
    input wire logic        receive_pin,
    input wire logic        transmit_pin_oe,
    input wire logic        request_to_send_pin_oe,
    input wire logic        bclk_pin_oe,
    input wire logic        irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // read address taken, then its target
    sequence ar_take; s_axi_arvalid && s_axi_arready; endsequence
    sequence ar_bad; ar_take ##0 (s_axi_araddr > ADDR_MASK); endsequence
    sequence ar_mode; ar_take ##0 (s_axi_araddr == ADDR_MODE); endsequence
    a_reset_vals: assert property ($fell(sys_rst) |-> core_hold_idle && !irq)
        else $error("reset state wrong");
    a_off_pins: assert property (core_hold_idle |->
        !(transmit_pin_oe || request_to_send_pin_oe || bclk_pin_oe))
        else $error("pin driven while off");
    a_off_run: assert property (core_hold_idle |-> !core_run)
        else $error("running while off");
    a_rx_direct: assert property (transmit_pin_oe |-> core_rx == $past(receive_pin))
        else $error("rx path wrong");
    a_mode_gaps: assert property (ar_mode |=> s_axi_rvalid && !s_axi_rdata[14]
        && !s_axi_rdata[10])
        else $error("unimplemented bit set");
    a_bad_addr: assert property (ar_bad |=> s_axi_rresp == AXI_SLVERR && s_axi_rdata == 0)
        else $error("unmapped read answer");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
endmodule
bind umc_top umc_chk chk (.*);

/* File: tb/umc_remote.sv */
`timescale 1ns/100ps
module umc_remote (
    // clock
    input  wire logic sys_clk,
    // line
    output logic      receive_pin,
    output logic      clear_to_send_pin
);
    // line idles high, peer always ready to take data
    initial begin
        receive_pin = 1'b1;
        clear_to_send_pin = 1'b1;
    end
    // sync character, lsb first: falling start edge, then rising edge
    task automatic send_sync;
        logic [9:0] f;
        f = {1'b1, 8'h55, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge sys_clk);
            receive_pin <= f[i];
        end
    endtask
endmodule

/* File: tb/umc_tb_top.sv */
`timescale 1ns/100ps
module umc_tb_top
    import umc_pkg::*;
;
    logic        sys_clk = 0, sys_rst = 1, dev_idle = 0, dev_sleep = 0;
    logic        core_tx = 1, core_rts = 1, core_bclk = 0, auto_baud_enable_done = 0;
    logic [3:0]  s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rr, br;
    logic        core_rx, core_run, core_hold_idle, core_ir_en, core_rts_simplex;
    logic        core_auto_baud_enable_go, core_cts, irq, receive_pin, clear_to_send_pin;
    logic        transmit_pin, transmit_pin_oe, request_to_send_pin;
    logic        request_to_send_pin_oe, bclk_pin, bclk_pin_oe;
    logic [2:0]  oe_exp [4] = '{3'b100, 3'b110, 3'b110, 3'b101};
    int          miscompares = 0, samples_checked = 0, cycles = 0;
    umc_top dut (.*);
    umc_remote rem (.sys_clk, .receive_pin, .clear_to_send_pin);
    // free-running clock
    initial forever #20 sys_clk = ~sys_clk;
    // hang guard, well above the fewer than two hundred cycles the tests need
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // each channel released on its own ready; bready dropped a cycle apart
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0000, d};
        s_axi_wstrb <= 4'h3;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        br = s_axi_bresp;
        s_axi_bready <= 1'b0;
        tick(1);
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
        tick(1);
        chk(rd, e);
        chk(rr, er);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // main sequence
    initial begin
        tick(2);
        sys_rst <= 1'b0;
        tick(1);
        rd_chk(ADDR_MODE, 0, AXI_OKAY);
        rd_chk(ADDR_MASK, 0, AXI_OKAY);
        chk(core_hold_idle, 1);
        wr(ADDR_MODE, 16'hffff);
        chk(br, AXI_OKAY);
        tick(2);
        rd_chk(ADDR_MODE, 32'h0000bbff, AXI_OKAY);
        chk(core_ir_en, 0);
        chk(core_rts_simplex, 1);
        chk({transmit_pin_oe, request_to_send_pin_oe, bclk_pin_oe}, 3'b001);
        core_tx <= 1'b0;
        tick(2);
        chk(core_rx, 0);
        chk(core_auto_baud_enable_go, 1);
        rem.send_sync();
        auto_baud_enable_done <= 1'b1;
        tick(1);
        auto_baud_enable_done <= 1'b0;
        tick(2);
        rd_chk(ADDR_MODE, 32'h0000bbdf, AXI_OKAY);
        rd_chk(ADDR_STATUS, 2, AXI_OKAY);
        dev_idle <= 1'b1;
        tick(2);
        chk(core_run, 0);
        // every pin usage code, codec on with 16x clock, idle-stop off
        for (int u = 0; u < 4; u++) begin
            wr(ADDR_MODE, {6'h24, u[1:0], 8'h00});
            tick(2);
            chk(core_ir_en, 1);
            chk({transmit_pin_oe, request_to_send_pin_oe, bclk_pin_oe}, oe_exp[u]);
            chk(core_cts, u == 2);
            chk(core_run, 1);
            chk(core_rts_simplex, 0);
            chk(core_rx, 1);
            chk({transmit_pin, request_to_send_pin, bclk_pin}, 3'b010);
        end
        wr(ADDR_MODE, 16'h0000);
        tick(2);
        chk({transmit_pin_oe, request_to_send_pin_oe, bclk_pin_oe}, 0);
        chk({core_hold_idle, core_run}, 2'b10);
        // wake event while masked, then unmask, then clear by read
        dev_sleep <= 1'b1;
        wr(ADDR_MODE, 16'h8080);
        rem.send_sync();
        tick(3);
        chk(irq, 0);
        wr(ADDR_MASK, 16'h0003);
        tick(2);
        chk(irq, 1);
        rd_chk(ADDR_STATUS, 1, AXI_OKAY);
        tick(2);
        chk(irq, 0);
        wr(4'hc, 16'hffff);
        chk(br, AXI_SLVERR);
        rd_chk(ADDR_MODE, 32'h00008000, AXI_OKAY);
        rd_chk(4'hc, 0, AXI_SLVERR);
        tally_and_finish();
    end
endmodule
